// >>> pkg/eirq_pkg.sv
// Purpose: Constants for the external interrupt request input controller.
// Assumes: Single 8-bit status and control register on a plain register port.
// Notes: Offset and reset value are local choices where none is printed.

package eirq_pkg;
    localparam int unsigned addr_width = 8;
    localparam logic [7:0] ext_request_status_control_offset = 8'h00;
    localparam logic [7:0] ext_request_status_control_reset = 8'h00;
    localparam int unsigned mode_bit = 0;
    localparam int unsigned irq_enable_bit = 1;
    localparam int unsigned acknowledge_bit = 2;
    localparam int unsigned flag_bit = 3;
    localparam int unsigned function_enable_bit = 4;
    localparam int unsigned polarity_bit = 5;
endpackage : eirq_pkg

// >>> src/eirq_sync.sv
// Purpose: Two-stage synchroniser for the request input.
// Assumes: Clock enable freezes both stages.
// Notes: The first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none

module eirq_sync (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic async_in,
    output logic sync_out
);
    logic meta;
    logic next_meta;
    logic next_sync_out;

    always_comb begin
        next_meta = meta;
        next_sync_out = sync_out;
        if (!reset_n) begin
            next_meta = 1'b1;
            next_sync_out = 1'b1;
        end else if (clk_en) begin
            next_meta = async_in;
            next_sync_out = meta;
        end
    end

    always_ff @(posedge clk) begin
        meta <= next_meta;
        sync_out <= next_sync_out;
    end
endmodule : eirq_sync

`default_nettype wire

// >>> src/eirq_ctrl.sv
// Purpose: Status and control logic for one maskable external request input.
// Assumes: Request source idles high after reset; registers on a plain port.
// Notes: A detected event in the same cycle as an acknowledge keeps the flag set.
`timescale 1ns/100ps
`default_nettype none

module eirq_ctrl (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic crossbar_request_source,
    input wire logic [eirq_pkg::addr_width-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    output logic cpu_irq
);
    import eirq_pkg::*;

    // ------------------------------------------------------------
    // Request input synchronisation
    // ------------------------------------------------------------
    logic req_sync;

    eirq_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in(crossbar_request_source),
        .sync_out(req_sync)
    );

    // ------------------------------------------------------------
    // Control state and detection
    // ------------------------------------------------------------
    logic request_function_enable;
    logic detection_polarity_select;
    logic request_interrupt_enable;
    logic detection_mode_select;
    logic request_event_flag;
    logic req_prev;
    logic next_request_function_enable;
    logic next_detection_polarity_select;
    logic next_request_interrupt_enable;
    logic next_detection_mode_select;
    logic next_request_event_flag;
    logic next_req_prev;
    logic [7:0] next_rd_data;
    logic next_cpu_irq;
    logic asserted;
    logic asserted_prev;
    logic edge_event;
    logic level_hold;
    logic sel;
    logic ack;

    // Polarity decides which sampled level counts as asserted.
    function automatic logic is_asserted(input logic level, input logic rising);
        return rising ? level : ~level;
    endfunction : is_asserted

    always_comb begin
        sel = (addr == ext_request_status_control_offset);
        asserted = is_asserted(req_sync, detection_polarity_select);
        asserted_prev = is_asserted(req_prev, detection_polarity_select);
        edge_event = request_function_enable && asserted && !asserted_prev;
        level_hold = request_function_enable && detection_mode_select && asserted;
        ack = wr_en && sel && wr_data[acknowledge_bit];

        next_request_function_enable = request_function_enable;
        next_detection_polarity_select = detection_polarity_select;
        next_request_interrupt_enable = request_interrupt_enable;
        next_detection_mode_select = detection_mode_select;
        next_request_event_flag = request_event_flag;
        next_req_prev = req_prev;
        next_rd_data = 8'h00;
        next_cpu_irq = cpu_irq;

        if (!reset_n) begin
            next_request_function_enable = ext_request_status_control_reset[function_enable_bit];
            next_detection_polarity_select = ext_request_status_control_reset[polarity_bit];
            next_request_interrupt_enable = ext_request_status_control_reset[irq_enable_bit];
            next_detection_mode_select = ext_request_status_control_reset[mode_bit];
            next_request_event_flag = 1'b0;
            next_req_prev = 1'b1;
            next_cpu_irq = 1'b0;
        end else if (clk_en) begin
            next_req_prev = req_sync;
            if (wr_en && sel) begin
                next_request_function_enable = wr_data[function_enable_bit];
                next_detection_polarity_select = wr_data[polarity_bit];
                next_request_interrupt_enable = wr_data[irq_enable_bit];
                next_detection_mode_select = wr_data[mode_bit];
            end
            if (ack) begin
                next_request_event_flag = 1'b0;
            end
            // Set beats clear, and a held level blocks the clear.
            if (edge_event || level_hold) begin
                next_request_event_flag = 1'b1;
            end
            if (rd_en && sel) begin
                // Bits 7, 6 and the acknowledge bit keep the zero of the default above.
                next_rd_data[polarity_bit] = detection_polarity_select;
                next_rd_data[function_enable_bit] = request_function_enable;
                next_rd_data[flag_bit] = request_event_flag;
                next_rd_data[irq_enable_bit] = request_interrupt_enable;
                next_rd_data[mode_bit] = detection_mode_select;
            end
            next_cpu_irq = next_request_event_flag && next_request_interrupt_enable;
        end else begin
            next_rd_data = rd_data;
        end
    end

    always_ff @(posedge clk) begin
        request_function_enable <= next_request_function_enable;
        detection_polarity_select <= next_detection_polarity_select;
        request_interrupt_enable <= next_request_interrupt_enable;
        detection_mode_select <= next_detection_mode_select;
        request_event_flag <= next_request_event_flag;
        req_prev <= next_req_prev;
        rd_data <= next_rd_data;
        cpu_irq <= next_cpu_irq;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_disabled_no_set;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && !request_function_enable && !request_event_flag && !(wr_en && sel))
            |=> !request_event_flag;
    endproperty
    a_disabled_no_set: assert property (p_disabled_no_set)
        else $error("flag set while off");

    property p_edge_sets;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && edge_event) |=> request_event_flag;
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge did not set flag");

    property p_ack_clears;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && ack && !edge_event && !level_hold) |=> !request_event_flag;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear");

    property p_zero_ack;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && wr_en && sel && !wr_data[acknowledge_bit] && request_event_flag)
            |=> request_event_flag;
    endproperty
    a_zero_ack: assert property (p_zero_ack) else $error("zero ack cleared flag");

    property p_ack_reads_zero;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && rd_en && sel) |=> (rd_data[acknowledge_bit] == 1'b0);
    endproperty
    a_ack_reads_zero: assert property (p_ack_reads_zero)
        else $error("ack bit read one");

    property p_level_holds;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && level_hold) |=> request_event_flag;
    endproperty
    a_level_holds: assert property (p_level_holds)
        else $error("level did not hold flag");

    property p_flag_read;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && rd_en && sel) |=> (rd_data[flag_bit] == $past(request_event_flag));
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag readback wrong");

    property p_irq_gate;
        @(posedge clk) disable iff (!reset_n)
        clk_en ##1 1'b1 |-> (cpu_irq == (request_event_flag && request_interrupt_enable));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not gated by enable");

    // A frozen cycle must leave the flag, function enable, read data and irq as they were.
    property p_freeze;
        @(posedge clk) disable iff (!reset_n)
        !clk_en |=> ($stable(request_event_flag) && $stable(request_function_enable)
            && $stable(rd_data) && $stable(cpu_irq));
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved while frozen");

    property p_flag_read_only;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && wr_en && sel && wr_data[flag_bit] && !request_event_flag && !edge_event
            && !level_hold) |=> !request_event_flag;
    endproperty
    a_flag_read_only: assert property (p_flag_read_only)
        else $error("flag written by software");

    // Written on the raw samples so that a fault in the polarity helper shows up.
    property p_rising_sets;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && request_function_enable && detection_polarity_select && req_sync && !req_prev)
            |=> request_event_flag;
    endproperty
    a_rising_sets: assert property (p_rising_sets)
        else $error("rising edge did not set flag");

    property p_edge_only_clear;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && ack && !detection_mode_select && !edge_event) |=> !request_event_flag;
    endproperty
    a_edge_only_clear: assert property (p_edge_only_clear)
        else $error("edge mode ack did not clear");

    c_edge: cover property (@(posedge clk) disable iff (!reset_n) edge_event && clk_en);
    c_level_ack: cover property (@(posedge clk) disable iff (!reset_n)
        ack && level_hold && clk_en);
    c_irq: cover property (@(posedge clk) disable iff (!reset_n) cpu_irq);
    c_freeze: cover property (@(posedge clk) disable iff (!reset_n) !clk_en);
endmodule : eirq_ctrl

`default_nettype wire

// >>> verification/eirq_src_model.sv
// Purpose: Model of the crossbar output that drives the request line.
// Assumes: The line idles at the deasserted level of the chosen polarity.
// Notes: Changes only after a clock edge, like any on-chip driver.
`timescale 1ns/100ps
`default_nettype none

module eirq_src_model (
    input wire logic clk,
    input wire logic req_on,
    input wire logic req_high,
    output logic crossbar_request_source
);
    // Idle high from time zero so reset never sees a false edge.
    initial begin
        crossbar_request_source = 1'b1;
        forever begin
            @(posedge clk);
            crossbar_request_source <= req_on ? req_high : !req_high;
        end
    end
endmodule : eirq_src_model

`default_nettype wire

// >>> verification/external_irq_input_ctrl_tb.sv
// Purpose: Self-checking bench for the request input controller.
// Assumes: Register at offset 0x00; flag visible within six cycles.
// Notes: Clock enable is dropped once to show that a write is frozen out.
`timescale 1ns/100ps
`default_nettype none

module external_irq_input_ctrl_tb;
    import eirq_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic req_on = 1'b0;
    logic req_high = 1'b0;
    logic src;
    logic [7:0] rd_data;
    logic cpu_irq;
    int miscompares = 0;
    int cmp_count = 0;

    eirq_src_model src_u (.clk(clk), .req_on(req_on), .req_high(req_high),
        .crossbar_request_source(src));
    eirq_ctrl dut_u (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .crossbar_request_source(src), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .cpu_irq(cpu_irq));

    initial begin
        forever #25 clk = ~clk;
    end

    // ----------------------------------------
    // Bus tasks and checks
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_irq(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t irq got %b expected %b", $time, got, exp);
        end
    endtask : chk_irq

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    // Checks the read value and that it stands for one cycle only.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rd_data, exp);
        @(posedge clk);
        #1 chk(rd_data, 8'h00);
    endtask : rd

    task automatic req(input logic on);
        req_on <= on;
        repeat (6) @(posedge clk);
    endtask : req

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h00, 8'h00);
        wr(8'h01, 8'h12);
        rd(8'h01, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h02);
        req(1'b1);
        rd(8'h00, 8'h02);
        chk_irq(cpu_irq, 1'b0);
        req(1'b0);
        wr(8'h00, 8'h12);
        rd(8'h00, 8'h12);
        req(1'b1);
        rd(8'h00, 8'h1a);
        chk_irq(cpu_irq, 1'b1);
        wr(8'h00, 8'h12);
        rd(8'h00, 8'h1a);
        wr(8'h00, 8'h16);
        rd(8'h00, 8'h12);
        chk_irq(cpu_irq, 1'b0);
        req(1'b0);
        wr(8'h00, 8'h10);
        req(1'b1);
        rd(8'h00, 8'h18);
        chk_irq(cpu_irq, 1'b0);
        wr(8'h00, 8'h17);
        rd(8'h00, 8'h1b);
        wr(8'h00, 8'h17);
        rd(8'h00, 8'h1b);
        chk_irq(cpu_irq, 1'b1);
        req(1'b0);
        rd(8'h00, 8'h1b);
        wr(8'h00, 8'h17);
        rd(8'h00, 8'h13);
        wr(8'h00, 8'h20);
        req_high <= 1'b1;
        req(1'b0);
        wr(8'h00, 8'h3a);
        rd(8'h00, 8'h32);
        @(posedge clk);
        clk_en <= 1'b0;
        wr(8'h00, 8'h00);
        clk_en <= 1'b1;
        rd(8'h00, 8'h32);
        req(1'b1);
        rd(8'h00, 8'h3a);
        chk_irq(cpu_irq, 1'b1);
        wr(8'h00, 8'h36);
        rd(8'h00, 8'h32);
        wr(8'h00, 8'h33);
        rd(8'h00, 8'h3b);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h00, 8'h00);
        chk_irq(cpu_irq, 1'b0);
        end_sim();
    end

    initial begin
        repeat (2000) @(posedge clk);
        miscompares++;
        end_sim();
    end
endmodule : external_irq_input_ctrl_tb

`default_nettype wire
